// ===== core/urxse_pkg.sv
// constants for the ulpi receive status byte encoder
// Function
// (R1) line condition code sits in status bits 1..0, low bit in bit 0
// (R2) bus-voltage state field sits in status bits 3..2
// (R3) receive event field sits in status bits 5..4
// (R4) status bit 6 follows the id pin level
// (R5) status bit 7 is the alternate interrupt flag, unused by default
// (R6) enabled b-session-valid edges send a byte with the alternate flag set
// (R7) any data-line change sends a fresh status byte; the code sends on status field changes, ignoring dplus/dminus in high speed
// (R8) pulldown settings pick peripheral or host line encoding
// (R9) a dual-role link decodes line condition per its current role
// (R10) peripheral: full speed reports bus levels, high speed squelch or not
// (R11) host: low speed and full speed report bus levels in any setting
// (R12) chirp reports squelch, receiver high, receiver low; else high speed
// (R13) each byte goes out with direction taken and byte on data lines
package urxse_pkg;

  // ---------------------------------------------------------------
  // status byte layout
  // ---------------------------------------------------------------
  localparam int LINE_LSB   = 0;
  localparam int VBUS_LSB   = 2;
  localparam int EVENT_LSB  = 4;
  localparam int ID_BIT     = 6;
  localparam int ALT_BIT    = 7;

  // ---------------------------------------------------------------
  // transceiver settings
  // ---------------------------------------------------------------
  localparam logic [1:0] XCVR_HIGH  = 2'h0;
  localparam logic [1:0] OPSET_CHIRP = 2'h2;
  localparam logic [1:0] LINE_SQUELCH = 2'h0;
  localparam logic [1:0] LINE_UNSQ    = 2'h1;
  localparam logic [1:0] LINE_UNSQ_LO = 2'h2;

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;

  // control register fields
  localparam int CTRL_DPPD    = 0;
  localparam int CTRL_DMPD    = 1;
  localparam int CTRL_XCVR    = 2;
  localparam int CTRL_TERM    = 4;
  localparam int CTRL_OPSET   = 5;
  localparam int CTRL_BRISE   = 7;
  localparam int CTRL_BFALL   = 8;
  localparam int CTRL_WIDTH   = 9;
  localparam logic [8:0] CTRL_RESET = 9'h007;

  // status register fields
  localparam int STAT_DIR     = 8;
  localparam int STAT_PEND    = 9;
  localparam int COUNT_WIDTH  = 16;

  typedef enum logic [1:0] {
    URXSE_IDLE,
    URXSE_TURN,
    URXSE_SEND,
    URXSE_BACK
  } urxse_state_t;

endpackage

// ===== core/urxse_line_enc.sv
// registered line condition encoder for peripheral and host roles
`timescale 1ns/1ps
module urxse_line_enc (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // port role and speed settings
  input  wire logic       dplus_pulldown_enable,
  input  wire logic       dminus_pulldown_enable,
  input  wire logic [1:0] transceiver_speed_select,
  input  wire logic       termination_select,
  input  wire logic [1:0] operation_setting,
  // line receivers
  input  wire logic       dplus,
  input  wire logic       dminus,
  input  wire logic       squelch,
  input  wire logic       fast_differential_receiver_out,
  // encoded line condition
  output logic [1:0]      line_code_q
);

  // -----------------------------------------------------
  // role and mode decode
  // -----------------------------------------------------
  // only the documented host combination selects host coding; any
  // other pulldown mix falls back to peripheral coding
  wire       host_role = dplus_pulldown_enable & dminus_pulldown_enable; // see (R8)
  wire       fast_sel  = (transceiver_speed_select == urxse_pkg::XCVR_HIGH);
  wire       chirp_per = ~host_role & termination_select; // see (R12)
  wire       chirp_hst = host_role & ~termination_select &
                         (operation_setting == urxse_pkg::OPSET_CHIRP); // see (R12)
  wire       chirp     = fast_sel & (chirp_per | chirp_hst);
  // full and low speed: {dm,dp} gives SE0/J/K/SE1 and LS K/J alike
  wire [1:0] bus_code  = {dminus, dplus}; // see (R10) (R11)
  wire [1:0] hs_code   = squelch ? urxse_pkg::LINE_SQUELCH
                                 : urxse_pkg::LINE_UNSQ; // see (R10)
  wire [1:0] chirp_code = squelch ? urxse_pkg::LINE_SQUELCH :
                          fast_differential_receiver_out ? urxse_pkg::LINE_UNSQ
                                                         : urxse_pkg::LINE_UNSQ_LO;
  wire [1:0] line_d    = ~fast_sel ? bus_code :
                         chirp     ? chirp_code : hs_code; // see (R12)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_code_q <= 2'h0;
    end else begin
      line_code_q <= line_d;
    end
  end

endmodule

// ===== core/urxse_top.sv
// ulpi receive status byte encoder with apb control and ulpi send path
`timescale 1ns/1ps
module urxse_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // line receivers
  input  wire logic        dplus,
  input  wire logic        dminus,
  input  wire logic        squelch,
  input  wire logic        fast_differential_receiver_out,
  // bus voltage and receive event codes, already encoded
  input  wire logic [1:0]  vbus_state_code,
  input  wire logic [1:0]  receive_event_code,
  // id and b-session-valid levels
  input  wire logic        id_pin,
  input  wire logic        bsession_valid,
  // link owns the data lines (transmit or register access in progress)
  input  wire logic        link_bus_busy,
  // ulpi side
  output logic             dir,
  output logic [7:0]       data_out,
  output logic             data_oe
);

  // -----------------------------------------------------
  // control register
  // -----------------------------------------------------
  logic [urxse_pkg::CTRL_WIDTH-1:0]  ctrl_q;
  logic [urxse_pkg::COUNT_WIDTH-1:0] sent_count_q;
  logic                              pready_q;
  logic [31:0]                       prdata_q;
  logic                              pslverr_q;

  wire       dplus_pulldown_enable    = ctrl_q[urxse_pkg::CTRL_DPPD];
  wire       dminus_pulldown_enable   = ctrl_q[urxse_pkg::CTRL_DMPD];
  wire [1:0] transceiver_speed_select = ctrl_q[urxse_pkg::CTRL_XCVR +: 2];
  wire       termination_select       = ctrl_q[urxse_pkg::CTRL_TERM];
  wire [1:0] operation_setting        = ctrl_q[urxse_pkg::CTRL_OPSET +: 2];
  wire       brise_en                 = ctrl_q[urxse_pkg::CTRL_BRISE];
  wire       bfall_en                 = ctrl_q[urxse_pkg::CTRL_BFALL];

  // -----------------------------------------------------
  // apb decode
  // -----------------------------------------------------
  // one wait state: pready is raised the cycle after the access
  // phase starts so that read data can come straight from a flop
  wire apb_access = psel & penable;
  wire apb_commit = apb_access & pready_q;
  wire hit_ctrl   = (paddr == urxse_pkg::ADDR_CTRL);
  wire hit_status = (paddr == urxse_pkg::ADDR_STATUS);
  wire hit_count  = (paddr == urxse_pkg::ADDR_COUNT);
  wire hit_any    = hit_ctrl | hit_status | hit_count;
  wire ctrl_wr    = apb_commit & pwrite & hit_ctrl;

  // -----------------------------------------------------
  // line encoder
  // -----------------------------------------------------
  logic [1:0] line_code_q;

  urxse_line_enc u_line_enc (
    .pclk                           (pclk),
    .presetn                        (presetn),
    .dplus_pulldown_enable          (dplus_pulldown_enable),
    .dminus_pulldown_enable         (dminus_pulldown_enable),
    .transceiver_speed_select       (transceiver_speed_select),
    .termination_select             (termination_select),
    .operation_setting              (operation_setting),
    .dplus                          (dplus),
    .dminus                         (dminus),
    .squelch                        (squelch),
    .fast_differential_receiver_out (fast_differential_receiver_out),
    .line_code_q                    (line_code_q)
  );

  // -----------------------------------------------------
  // status byte assembly
  // -----------------------------------------------------
  logic [6:0] last_sent_q;
  logic       alternate_interrupt_flag_q;
  logic       bvalid_prev_q;
  logic       prev_valid_q;
  urxse_pkg::urxse_state_t state_q;
  urxse_pkg::urxse_state_t state_d;

  wire [6:0] status_now;
  assign status_now[urxse_pkg::LINE_LSB  +: 2] = line_code_q;        // see (R1)
  assign status_now[urxse_pkg::VBUS_LSB  +: 2] = vbus_state_code;    // see (R2)
  assign status_now[urxse_pkg::EVENT_LSB +: 2] = receive_event_code; // see (R3)
  assign status_now[urxse_pkg::ID_BIT]         = id_pin;             // see (R4)

  // b-session-valid edge reporting, only when enabled
  wire bvalid_rise = prev_valid_q & bsession_valid & ~bvalid_prev_q;
  wire bvalid_fall = prev_valid_q & ~bsession_valid & bvalid_prev_q;
  wire alt_event   = (bvalid_rise & brise_en) | (bvalid_fall & bfall_en); // see (R6)

  // a changed field (line condition included) or an alternate event
  wire field_change = (status_now != last_sent_q);  // see (R7)
  wire pending      = field_change | alternate_interrupt_flag_q;

  // byte taken at the send cycle; the alternate flag rides in bit 7
  wire       send_now  = (state_d == urxse_pkg::URXSE_SEND);
  wire [7:0] send_byte = {alternate_interrupt_flag_q, status_now}; // see (R5)

  // -----------------------------------------------------
  // send sequencer
  // -----------------------------------------------------
  // idle -> turn (dir up, lines released) -> send (byte driven) ->
  // back (dir down); a byte still pending at send goes out back to back
  always_comb begin
    state_d = state_q;
    case (state_q)
      urxse_pkg::URXSE_IDLE: begin
        if (pending && !link_bus_busy) begin
          state_d = urxse_pkg::URXSE_TURN;
        end
      end
      urxse_pkg::URXSE_TURN: begin
        state_d = urxse_pkg::URXSE_SEND;
      end
      urxse_pkg::URXSE_SEND: begin
        if (pending) begin
          state_d = urxse_pkg::URXSE_SEND;
        end else begin
          state_d = urxse_pkg::URXSE_BACK;
        end
      end
      urxse_pkg::URXSE_BACK: begin
        state_d = urxse_pkg::URXSE_IDLE;
      end
      default: begin
        state_d = urxse_pkg::URXSE_IDLE;
      end
    endcase
  end

  wire dir_d = (state_d == urxse_pkg::URXSE_TURN) | send_now; // see (R13)

  // -----------------------------------------------------
  // sequencer state
  // -----------------------------------------------------
  // state only; every ulpi output below is decoded from state_d
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= urxse_pkg::URXSE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------
  // ulpi outputs
  // -----------------------------------------------------
  // each output is decoded from state_d and registered, so it lines up
  // with state_q and the link never sees a decode glitch
  // dir drops together with data_oe: the first low cycle of dir is the
  // turnaround back, and the link drives only after it
  wire [7:0] data_d = send_now ? send_byte : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= 1'b0;
    end else begin
      dir <= dir_d;          // see (R13)
    end
  end

  // lines released during the turn cycle, driven only while sending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= send_now;   // see (R13)
    end
  end

  // idle value on the data lines is zero between bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 8'h00;
    end else begin
      data_out <= data_d;    // see (R13)
    end
  end

  // -----------------------------------------------------
  // byte history
  // -----------------------------------------------------
  // record what was sent so only real changes trigger a new byte; it
  // resets to zero, so nonzero inputs at release send a first byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sent_q <= 7'h00;
    end else if (send_now) begin
      last_sent_q <= status_now;  // see (R7)
    end
  end

  // -----------------------------------------------------
  // b-session-valid edge history
  // -----------------------------------------------------
  // level seen last cycle; edges are found against it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bvalid_prev_q <= 1'b0;
    end else begin
      bvalid_prev_q <= bsession_valid;
    end
  end

  // the first cycle after reset reports no edge: the old level is unknown
  // and a pin already high at release must not look like a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_valid_q <= 1'b0;
    end else begin
      prev_valid_q <= 1'b1;
    end
  end

  // -----------------------------------------------------
  // alternate interrupt flag
  // -----------------------------------------------------
  // a new edge in the sending cycle wins over the clear, so an edge that
  // lands while a flagged byte goes out is reported by the next byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alternate_interrupt_flag_q <= 1'b0;
    end else if (alt_event) begin
      alternate_interrupt_flag_q <= 1'b1;  // see (R6)
    end else if (send_now) begin
      alternate_interrupt_flag_q <= 1'b0;
    end
  end

  // -----------------------------------------------------
  // sent byte counter
  // -----------------------------------------------------
  // wraps silently; software takes differences between two reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_count_q <= '0;
    end else if (send_now) begin
      sent_count_q <= sent_count_q + 1'b1;
    end
  end

  // -----------------------------------------------------
  // apb read mux
  // -----------------------------------------------------
  // offsets outside the map read as zero
  logic [7:0]  last_byte_q;
  wire  [31:0] rd_status;

  // status word: last byte, direction and the pending change
  assign rd_status[urxse_pkg::STAT_DIR-1:0]   = last_byte_q;
  assign rd_status[urxse_pkg::STAT_DIR]       = dir;
  assign rd_status[urxse_pkg::STAT_PEND]      = pending;
  assign rd_status[31:urxse_pkg::STAT_PEND+1] = '0;

  wire [31:0] rd_ctrl   = {{(32-urxse_pkg::CTRL_WIDTH){1'b0}}, ctrl_q};
  wire [31:0] rd_count  = {{(32-urxse_pkg::COUNT_WIDTH){1'b0}}, sent_count_q};
  wire [31:0] rd_mux    = hit_ctrl   ? rd_ctrl   :
                          hit_status ? rd_status :
                          hit_count  ? rd_count  : 32'h00000000;

  // -----------------------------------------------------
  // last byte sent
  // -----------------------------------------------------
  // kept apart from data_out, which returns to zero after the last byte of each back-to-back run;
  // software reads it back through the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_byte_q <= 8'h00;
    end else if (send_now) begin
      last_byte_q <= send_byte;
    end
  end

  // -----------------------------------------------------
  // control register
  // -----------------------------------------------------
  // only a completed write to the control offset lands; the reset value
  // selects the host role at full speed with both edge reports off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= urxse_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[urxse_pkg::CTRL_WIDTH-1:0];
    end
  end

  // -----------------------------------------------------
  // apb response
  // -----------------------------------------------------
  // first access cycle of a transfer; ready follows one cycle later and
  // then drops, so each transfer sees exactly one wait state
  wire apb_first = apb_access & ~pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_first;
    end
  end

  // read data stands only with ready; writes return zero, so a late
  // sample never shows a stale word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (apb_first && !pwrite) begin
      prdata_q <= rd_mux;
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  // unmapped offsets answer with an error and the write is dropped;
  // an error read returns zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (apb_first) begin
      pslverr_q <= ~hit_any;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule

// ===== verification/urxse_top_asserts.sv
// port checker for the receive status byte encoder
`timescale 1ns/1ps
module urxse_top_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // status inputs
  input wire logic [1:0] vbus_state_code,
  input wire logic [1:0] receive_event_code,
  input wire logic       id_pin,
  input wire logic       link_bus_busy,
  // ulpi side
  input wire logic       dir,
  input wire logic [7:0] data_out,
  input wire logic       data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_dir; data_oe |-> dir; endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("data driven without dir");
  property p_turn_in; $rose(dir) |-> !data_oe ##1 data_oe; endproperty
  a_turn_in: assert property (p_turn_in) else $error("bad turnaround in");
  // dir drops with data_oe; its first low cycle is the turnaround back
  property p_turn_out; $fell(data_oe) |-> !dir ##1 !dir; endproperty
  a_turn_out: assert property (p_turn_out) else $error("bad turnaround out");
  property p_busy; !dir && link_bus_busy |=> !dir; endproperty
  a_busy: assert property (p_busy) else $error("bus taken while link busy");
  property p_idle; !data_oe |-> data_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("data not idle");
  // a byte carries the field levels of the cycle before it is driven
  property p_id; data_oe |-> data_out[6] == $past(id_pin); endproperty
  a_id: assert property (p_id) else $error("id bit wrong");
  property p_vbus;
    data_oe |-> data_out[3:2] == $past(vbus_state_code);
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus field wrong");
  property p_event;
    data_oe |-> data_out[5:4] == $past(receive_event_code);
  endproperty
  a_event: assert property (p_event) else $error("event field wrong");
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("apb ready timing wrong");
endmodule

// ===== verification/urxse_link_model.sv
// link controller model that collects status bytes from the ulpi side
`timescale 1ns/1ps
module urxse_link_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // ulpi side
  input  wire logic       dir,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            link_bus_busy,
  // bench control and observation
  input  wire logic       hold_bus,
  output logic [7:0]      last_byte_q,
  output logic [15:0]     byte_cnt_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_bus_busy <= 1'b0;
      last_byte_q   <= 8'h00;
      byte_cnt_q    <= 16'h0000;
    end else begin
      // the link may only claim an idle bus
      link_bus_busy <= hold_bus && !dir;
      // role-dependent line decoding is left to the bench
      if (dir && data_oe) begin
        last_byte_q <= data_out;
        byte_cnt_q  <= byte_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// ===== verification/urxse_top_tb.sv
// self-checking bench for the receive status byte encoder
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module urxse_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dplus, dminus, squelch;
  logic fast_differential_receiver_out, id_pin, bsession_valid, link_bus_busy;
  logic dir, data_oe, hold, err, e;
  logic [7:0]  paddr, data_out, last_byte_q, prev;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  vbus_state_code, receive_event_code;
  logic [15:0] byte_cnt_q;
  logic [8:0]  ctrl;
  logic [8:0]  cfg [11] = '{9'h007, 9'h00f, 9'h08b, 9'h103, 9'h023, 9'h063, 9'h1c3,
                            9'h014, 9'h19c, 9'h000, 9'h090};
  int          error_cnt, checked, cyc, seed;
  urxse_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .dplus, .dminus, .squelch, .fast_differential_receiver_out,
    .vbus_state_code, .receive_event_code, .id_pin, .bsession_valid, .link_bus_busy,
    .dir, .data_out, .data_oe);
  urxse_link_model u_link (.pclk, .presetn, .dir, .data_out, .data_oe, .link_bus_busy,
    .hold_bus(hold), .last_byte_q, .byte_cnt_q);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected low seven bits of the status byte for control word c
  function automatic logic [6:0] fields(logic [8:0] c);
    logic [1:0] ln;
    logic       ch;
    ch = (c[1:0] == 2'h3) ? (!c[4] && c[6:5] == 2'h2) : c[4];
    if (c[3:2] != 2'h0) ln = {dminus, dplus};
    else if (squelch) ln = 2'h0;
    else ln = (ch && !fast_differential_receiver_out) ? 2'h2 : 2'h1;
    return {id_pin, receive_event_code, vbus_state_code, ln};
  endfunction
  // an unchanged status sends nothing, so the last byte must still stand
  task automatic settle(input logic edge_seen);
    logic [6:0] f;
    repeat (8) @(posedge pclk);
    f = fields(ctrl);
    if (f != prev[6:0] || edge_seen) prev = {edge_seen, f};
    `CHK(last_byte_q, prev)
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hold, bsession_valid} = '0;
    {dplus, dminus, squelch, fast_differential_receiver_out, id_pin} = '0;
    {vbus_state_code, receive_event_code} = '0;
    prev = 8'h00;
    ctrl = 9'h007;
    seed = $urandom(59);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0007)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    hold <= 1'b1;
    repeat (3) @(posedge pclk);
    id_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK(byte_cnt_q, 16'h0000)
    hold <= 1'b0;
    settle(1'b0);
    $display("test busy done");
    foreach (cfg[i]) begin
      ctrl = cfg[i];
      apb(1'b1, 8'h00, {23'h0, ctrl});
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, {23'h0, ctrl})
      settle(1'b0);
      repeat (6) begin
        @(posedge pclk);
        {dplus, dminus, squelch, fast_differential_receiver_out, id_pin,
         vbus_state_code, receive_event_code} <= 9'($urandom);
        settle(1'b0);
        @(posedge pclk);
        e = bsession_valid ? ctrl[8] : ctrl[7];
        bsession_valid <= !bsession_valid;
        settle(e);
      end
      $display("test mode %h done", ctrl);
    end
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, {16'h0, byte_cnt_q})
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], last_byte_q)
    $display("test counters done");
    final_report();
  end
endmodule
bind urxse_top urxse_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready,
  .vbus_state_code, .receive_event_code, .id_pin, .link_bus_busy, .dir, .data_out,
  .data_oe);
